// [design/rffe_pkg.sv]
`default_nettype none
package rffe_pkg;
  // Register addresses on the plain register port
  localparam logic [7:0] RFFE_ADDR_CAL = 8'h26; // Calibration reference register
  localparam logic [7:0] RFFE_ADDR_DPC = 8'h27; // Drive strength configuration
  localparam logic [7:0] RFFE_ADDR_EMD = 8'h28; // Noise error filter control
  localparam logic [7:0] RFFE_ADDR_ANT = 8'h29; // Antenna switch control

  // Calibration reference register fields
  localparam int RFFE_GEAR_HI = 13;
  localparam int RFFE_GEAR_LO = 10;
  localparam int RFFE_LEVEL_HI = 9;
  localparam int RFFE_LEVEL_LO = 0;

  // Drive strength fields
  localparam int RFFE_DPC_HI = 19; // Highest implemented bit
  localparam int RFFE_CCW_LO = 16;
  localparam int RFFE_CMOD_LO = 12;
  localparam int RFFE_RMOD_LO = 8;
  localparam int RFFE_RCW_LO = 4;
  localparam int RFFE_MAX_BIT = 3;
  localparam int RFFE_AMP_HI = 2;
  localparam int RFFE_AMP_LO = 1;
  localparam int RFFE_REF_BIT = 0;

  // Noise error filter fields
  localparam int RFFE_EMD_HI = 9;
  localparam int RFFE_TMR_HI = 9;
  localparam int RFFE_TMR_LO = 8;
  localparam int RFFE_THR_HI = 5;
  localparam int RFFE_THR_LO = 2;
  localparam int RFFE_NOEMD_BIT = 1;
  localparam int RFFE_EN_BIT = 0;
  localparam logic [7:0] RFFE_MIN_NOTIFY_LEN = 8'h04; // Bytes, checksum excluded

  // Antenna switch fields
  localparam int RFFE_ANT_HI = 7;
  localparam int RFFE_INV_BIT = 7;
  localparam int RFFE_AUTO_BIT = 6;
  localparam int RFFE_ARST_BIT = 5;
  localparam int RFFE_RMSEL_BIT = 4;
  localparam int RFFE_SHORT_HI = 3;
  localparam int RFFE_SHORT_LO = 2;
  localparam int RFFE_MODSEL_HI = 1;
  localparam int RFFE_MODSEL_LO = 0;

  // Source select codes for short and modulation outputs
  localparam logic [1:0] RFFE_SEL_ZERO = 2'h0;
  localparam logic [1:0] RFFE_SEL_ONE = 2'h1;
  localparam logic [1:0] RFFE_SEL_ENV = 2'h2;

  // Calibration settle time, least time rounded up to cycles
  localparam int RFFE_CLK_PERIOD_NS = 100;
  localparam int RFFE_CAL_SETTLE_NS = 2000;
  localparam int RFFE_CAL_CYCLES = (RFFE_CAL_SETTLE_NS + RFFE_CLK_PERIOD_NS - 1)
                                   / RFFE_CLK_PERIOD_NS;
  localparam int RFFE_CAL_CNT_W = 5;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    RFFE_CAL_IDLE = 3'b001,
    RFFE_CAL_SETTLE = 3'b010,
    RFFE_CAL_CAPTURE = 3'b100
  } rffe_cal_state_e;
endpackage
`default_nettype wire

// [design/rffe_cal_seq.sv]
`timescale 1ns/10ps
`default_nettype none
module rffe_cal_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [9:0] level_in,
  output logic busy_out,
  output logic done_out,
  output logic [9:0] level_out
);
  import rffe_pkg::*;

  rffe_cal_state_e state_r; // Sequencer state
  logic [RFFE_CAL_CNT_W-1:0] cnt_r; // Settle counter

  // State walk; a new start restarts settling so the latest gear wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= RFFE_CAL_IDLE;
    end else if (start_in) begin
      state_r <= RFFE_CAL_SETTLE;
    end else begin
      case (state_r)
        RFFE_CAL_IDLE: state_r <= RFFE_CAL_IDLE;
        RFFE_CAL_SETTLE: begin
          if (cnt_r == RFFE_CAL_CNT_W'(RFFE_CAL_CYCLES - 1)) begin
            state_r <= RFFE_CAL_CAPTURE;
          end
        end
        RFFE_CAL_CAPTURE: state_r <= RFFE_CAL_IDLE;
        default: state_r <= RFFE_CAL_IDLE;
      endcase
    end
  end

  // Settle count, cleared on every start
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (start_in || state_r != RFFE_CAL_SETTLE) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Level is sampled once the front end has settled on the new gear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= (state_r == RFFE_CAL_CAPTURE) && !start_in;
      if (state_r == RFFE_CAL_CAPTURE) begin
        level_out <= level_in;
      end
    end
  end

  assign busy_out = (state_r != RFFE_CAL_IDLE);
endmodule
`default_nettype wire

// [design/rffe_ant_mux.sv]
`timescale 1ns/10ps
`default_nettype none
module rffe_ant_mux (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] ctl_in,
  input wire logic card_mode_in,
  input wire logic alm_in,
  input wire logic tx_active_in,
  input wire logic tx_envelope_in,
  input wire logic rdr_mod_ctl_in,
  output logic ant_short_out,
  output logic ant_mod_out
);
  import rffe_pkg::*;

  // Map a 2-bit source code onto the envelope
  function automatic logic sel_src(input logic [1:0] code, input logic env);
    case (code)
      RFFE_SEL_ZERO: sel_src = 1'b0;
      RFFE_SEL_ONE: sel_src = 1'b1;
      RFFE_SEL_ENV: sel_src = env;
      default: sel_src = ~env;
    endcase
  endfunction

  logic auto_w; // Hardware switching for active modulation
  logic plm_short_w; // Passive short before inversion
  assign auto_w = ctl_in[RFFE_AUTO_BIT];
  assign plm_short_w = sel_src(ctl_in[RFFE_SHORT_HI:RFFE_SHORT_LO], tx_envelope_in);

  // Registered so the analog switches never see decode glitches
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ant_short_out <= 1'b0;
      ant_mod_out <= 1'b0;
    end else if (!card_mode_in) begin
      ant_short_out <= 1'b0;
      ant_mod_out <= ctl_in[RFFE_RMSEL_BIT] ? rdr_mod_ctl_in : tx_envelope_in;
    end else if (alm_in && ctl_in[RFFE_ARST_BIT]) begin
      ant_short_out <= 1'b0;
      ant_mod_out <= 1'b0;
    end else if (alm_in && auto_w) begin
      ant_short_out <= ~tx_active_in;
      ant_mod_out <= tx_active_in;
    end else begin
      ant_short_out <= plm_short_w ^ (ctl_in[RFFE_INV_BIT] && tx_active_in && !auto_w);
      ant_mod_out <= sel_src(ctl_in[RFFE_MODSEL_HI:RFFE_MODSEL_LO], tx_envelope_in);
    end
  end

  // Passive constant-one short selection
  property p_short_const;
    @(posedge clk_in) disable iff (rst_in)
    card_mode_in && !alm_in && ctl_in[RFFE_SHORT_HI:RFFE_SHORT_LO] == RFFE_SEL_ONE
      && !ctl_in[RFFE_INV_BIT] |=> ant_short_out;
  endproperty
  a_short_const: assert property (p_short_const) else $error("short not one");

  // Passive envelope on modulation output
  property p_mod_env;
    @(posedge clk_in) disable iff (rst_in)
    card_mode_in && !alm_in && ctl_in[RFFE_MODSEL_HI:RFFE_MODSEL_LO] == RFFE_SEL_ENV
      |=> ant_mod_out == $past(tx_envelope_in);
  endproperty
  a_mod_env: assert property (p_mod_env) else $error("mod not envelope");
endmodule
`default_nettype wire

// [design/rffe_cfg_regs.sv]
// Overview of operation
// - Unwritten calibration read starts power-control calibration
// - That read returns gear and reference level
// - Write sets gear, calibration derives level
// - Four 4-bit driver conductance fields held
// - Bit 0 references carrier to supply
// - Max-output bit and 2-bit carrier amplitude
// - Two-bit supervision timer select, 11 reserved
// - Short errored frames below threshold are noise
// - Bit 1: under 4 ignored, else notify
// - Bit 7 inverts card short while sending; code inverts only while bit 6 is clear
// - Bit 6 enables automatic active-modulation switching
// - Bit 5 resets active-modulation antenna settings
// - Bit 4 picks reader-mode modulation source
// - Short select code drives passive short
// - Modulation select code drives passive modulation
// - Gear 4 bits, level 10 bits, reset zero
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module rffe_cfg_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Analog side, asynchronous to clk_in
  input wire logic [3:0] dpc_gear_in,
  input wire logic [9:0] meas_level_in,
  // Same-clock sequencer and transceiver signals
  input wire logic low_power_card_detect_start_in,
  input wire logic card_mode_in,
  input wire logic alm_in,
  input wire logic tx_active_in,
  input wire logic tx_envelope_in,
  input wire logic rdr_mod_ctl_in,
  input wire logic err_frame_in,
  input wire logic [7:0] err_len_in,
  // Calibration control
  output logic [3:0] cal_gear_out,
  output logic [9:0] cal_level_out,
  output logic cal_busy_out,
  // Driver settings
  output logic [3:0] card_carrier_conductance_out,
  output logic [3:0] card_modulation_conductance_out,
  output logic [3:0] reader_modulation_conductance_out,
  output logic [3:0] reader_carrier_conductance_out,
  output logic reader_max_output_select_out,
  output logic [1:0] reader_carrier_amplitude_out,
  output logic carrier_reference_to_supply_out,
  // Disturbance handling
  output logic [2:0] supervision_timer_out,
  output logic noise_drop_out,
  output logic err_notify_out,
  // Antenna switches
  output logic ant_short_out,
  output logic ant_mod_out
);
  import rffe_pkg::*;

  // Register storage, reserved bits not implemented
  logic [RFFE_GEAR_HI-RFFE_GEAR_LO:0] gear_r; // Calibration gear
  logic [RFFE_LEVEL_HI:0] level_r; // Calibration reference level
  logic [RFFE_DPC_HI:0] dpc_r; // Drive strength configuration
  logic [RFFE_EMD_HI:0] emd_r; // Noise error filter control
  logic [RFFE_ANT_HI:0] ant_r; // Antenna switch control
  logic written_r; // Calibration register written since last detection start
  logic [31:0] rdata_r; // Read data for the cycle after a read

  // Synchronisers for the analog-side buses
  logic [3:0] gear_s1_r;
  logic [3:0] gear_s2_r;
  logic [9:0] lvl_s1_r;
  logic [9:0] lvl_s2_r;

  // Decoded accesses
  logic cal_rd_w; // Read of the calibration register
  logic cal_wr_w; // Write of the calibration register
  logic self_cal_w; // Read that calibrates on the present power-control gear
  logic cal_start_w; // Start for the settling sequencer
  logic cal_done_w; // Sequencer captured a level
  logic [9:0] cal_lvl_w; // Level from the sequencer
  logic [7:0] thr_w; // Noise threshold widened to the length width
  logic noise_w; // Errored frame classified as noise

  assign cal_rd_w = rd_in && (addr_in == RFFE_ADDR_CAL);
  assign cal_wr_w = wr_in && (addr_in == RFFE_ADDR_CAL);
  assign self_cal_w = cal_rd_w && !written_r;
  assign cal_start_w = cal_wr_w;

  // Two flops before the analog buses are used; values are quasi-static
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gear_s1_r <= '0;
      gear_s2_r <= '0;
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
    end else begin
      gear_s1_r <= dpc_gear_in;
      gear_s2_r <= gear_s1_r;
      lvl_s1_r <= meas_level_in;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  // Settling sequencer for gear-defined calibrations
  rffe_cal_seq u_cal (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(cal_start_w),
    .level_in(lvl_s2_r),
    .busy_out(cal_busy_out),
    .done_out(cal_done_w),
    .level_out(cal_lvl_w)
  );

  // Written flag; a write in the same cycle as a detection start wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      written_r <= 1'b0;
    end else if (cal_wr_w) begin
      written_r <= 1'b1;
    end else if (low_power_card_detect_start_in) begin
      written_r <= 1'b0;
    end
  end

  // Calibration gear and level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gear_r <= '0;
      level_r <= '0;
    end else if (self_cal_w) begin
      gear_r <= gear_s2_r;
      level_r <= lvl_s2_r;
    end else begin
      if (cal_wr_w) begin
        gear_r <= wdata_in[RFFE_GEAR_HI:RFFE_GEAR_LO];
      end
      if (cal_done_w) begin
        level_r <= cal_lvl_w;
      end
    end
  end

  // Written level bits are ignored: the device derives the level itself
  assign cal_gear_out = gear_r;
  assign cal_level_out = level_r;

  // Drive strength register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dpc_r <= '0;
    end else if (wr_in && addr_in == RFFE_ADDR_DPC) begin
      dpc_r <= wdata_in[RFFE_DPC_HI:0];
    end
  end

  // Driver fields straight from the register flops
  assign card_carrier_conductance_out = dpc_r[RFFE_CCW_LO+3:RFFE_CCW_LO];
  assign card_modulation_conductance_out = dpc_r[RFFE_CMOD_LO+3:RFFE_CMOD_LO];
  assign reader_modulation_conductance_out = dpc_r[RFFE_RMOD_LO+3:RFFE_RMOD_LO];
  assign reader_carrier_conductance_out = dpc_r[RFFE_RCW_LO+3:RFFE_RCW_LO];
  assign reader_max_output_select_out = dpc_r[RFFE_MAX_BIT];
  assign reader_carrier_amplitude_out = dpc_r[RFFE_AMP_HI:RFFE_AMP_LO];
  assign carrier_reference_to_supply_out = dpc_r[RFFE_REF_BIT];

  // Noise error filter register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      emd_r <= '0;
    end else if (wr_in && addr_in == RFFE_ADDR_EMD) begin
      emd_r <= wdata_in[RFFE_EMD_HI:0];
    end
  end

  // Supervision timer as one-hot; the reserved code selects none
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      supervision_timer_out <= 3'h1;
    end else begin
      case (emd_r[RFFE_TMR_HI:RFFE_TMR_LO])
        2'h0: supervision_timer_out <= 3'h1;
        2'h1: supervision_timer_out <= 3'h2;
        2'h2: supervision_timer_out <= 3'h4;
        default: supervision_timer_out <= 3'h0;
      endcase
    end
  end

  // Lengths exclude checksum bytes; the counting logic upstream strips them
  assign thr_w = {4'h0, emd_r[RFFE_THR_HI:RFFE_THR_LO]};
  assign noise_w = emd_r[RFFE_EN_BIT] && ((err_len_in < thr_w) ||
                   (emd_r[RFFE_NOEMD_BIT] && err_len_in < RFFE_MIN_NOTIFY_LEN));

  // Classify each errored frame: silently dropped or reported
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      noise_drop_out <= 1'b0;
      err_notify_out <= 1'b0;
    end else begin
      noise_drop_out <= err_frame_in && noise_w;
      err_notify_out <= err_frame_in && !noise_w;
    end
  end

  // Antenna switch register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ant_r <= '0;
    end else if (wr_in && addr_in == RFFE_ADDR_ANT) begin
      ant_r <= wdata_in[RFFE_ANT_HI:0];
    end
  end

  // Antenna short and modulation output selection
  rffe_ant_mux u_ant (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctl_in(ant_r),
    .card_mode_in(card_mode_in),
    .alm_in(alm_in),
    .tx_active_in(tx_active_in),
    .tx_envelope_in(tx_envelope_in),
    .rdr_mod_ctl_in(rdr_mod_ctl_in),
    .ant_short_out(ant_short_out),
    .ant_mod_out(ant_mod_out)
  );

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= '0;
    end else if (!rd_in) begin
      rdata_r <= '0;
    end else begin
      case (addr_in)
        RFFE_ADDR_CAL: begin
          if (self_cal_w) begin
            rdata_r <= {18'h0, gear_s2_r, lvl_s2_r};
          end else begin
            rdata_r <= {18'h0, gear_r, level_r};
          end
        end
        RFFE_ADDR_DPC: rdata_r <= {12'h0, dpc_r};
        RFFE_ADDR_EMD: rdata_r <= {22'h0, emd_r};
        RFFE_ADDR_ANT: rdata_r <= {24'h0, ant_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  assign rdata_out = rdata_r;

  // Unwritten read calibrates on the power-control gear
  property p_self_cal;
    @(posedge clk_in) disable iff (rst_in)
    self_cal_w |=> gear_r == $past(gear_s2_r) && level_r == $past(lvl_s2_r);
  endproperty
  a_self_cal: assert property (p_self_cal) else $error("read did not calibrate");

  // Read returns both gear and level
  property p_self_rdata;
    @(posedge clk_in) disable iff (rst_in)
    self_cal_w |=> rdata_out[RFFE_GEAR_HI:RFFE_GEAR_LO] == $past(gear_s2_r)
      && rdata_out[RFFE_LEVEL_HI:RFFE_LEVEL_LO] == $past(lvl_s2_r);
  endproperty
  a_self_rdata: assert property (p_self_rdata) else $error("bad calibration readback");

  // Write sets gear, marks the register written and starts the sequencer
  property p_wr_gear;
    @(posedge clk_in) disable iff (rst_in)
    cal_wr_w |=> gear_r == $past(wdata_in[RFFE_GEAR_HI:RFFE_GEAR_LO]) && written_r
      && cal_busy_out;
  endproperty
  a_wr_gear: assert property (p_wr_gear) else $error("gear write lost");

  // Uninterrupted calibration ends within 30 cycles after eight quiet cycles
  property p_cal_ends;
    @(posedge clk_in) disable iff (rst_in)
    cal_wr_w ##1 (!cal_wr_w)[*8] |-> ##[1:30] cal_done_w;
  endproperty
  a_cal_ends: assert property (p_cal_ends) else $error("calibration hung");

  // Card and reader carrier conductance fields follow writes
  property p_dpc_wr;
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == RFFE_ADDR_DPC |=> card_carrier_conductance_out
      == $past(wdata_in[RFFE_CCW_LO+3:RFFE_CCW_LO])
      && reader_carrier_conductance_out == $past(wdata_in[RFFE_RCW_LO+3:RFFE_RCW_LO]);
  endproperty
  a_dpc_wr: assert property (p_dpc_wr) else $error("drive fields stale");

  // Low drive bits follow writes
  property p_dpc_low;
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == RFFE_ADDR_DPC |=> {reader_max_output_select_out,
      reader_carrier_amplitude_out, carrier_reference_to_supply_out}
      == $past(wdata_in[RFFE_MAX_BIT:RFFE_REF_BIT]);
  endproperty
  a_dpc_low: assert property (p_dpc_low) else $error("low drive bits stale");

  // Reserved timer code selects no timer
  property p_tmr_rsvd;
    @(posedge clk_in) disable iff (rst_in)
    emd_r[RFFE_TMR_HI:RFFE_TMR_LO] == 2'h3 |=> supervision_timer_out == 3'h0;
  endproperty
  a_tmr_rsvd: assert property (p_tmr_rsvd) else $error("reserved timer used");

  // Short errored frames become noise
  property p_noise;
    @(posedge clk_in) disable iff (rst_in)
    err_frame_in && emd_r[RFFE_EN_BIT] && err_len_in < thr_w
      |=> noise_drop_out && !err_notify_out;
  endproperty
  a_noise: assert property (p_noise) else $error("noise not dropped");

  // Long errored frames with bit 1 are reported
  property p_notify;
    @(posedge clk_in) disable iff (rst_in)
    err_frame_in && emd_r[RFFE_NOEMD_BIT] && err_len_in >= RFFE_MIN_NOTIFY_LEN
      && err_len_in >= thr_w |=> err_notify_out && !noise_drop_out;
  endproperty
  a_notify: assert property (p_notify) else $error("error not reported");

  // Reserved noise error filter bits read zero
  property p_rsvd;
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == RFFE_ADDR_EMD |=> rdata_out[31:RFFE_EMD_HI+1] == 22'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  // Main scenarios
  c_self_cal: cover property (@(posedge clk_in) disable iff (rst_in) self_cal_w);
  c_wr_cal: cover property (@(posedge clk_in) disable iff (rst_in)
    cal_wr_w ##[1:30] cal_done_w);
  c_noise: cover property (@(posedge clk_in) disable iff (rst_in) noise_drop_out);
  c_notify: cover property (@(posedge clk_in) disable iff (rst_in) err_notify_out);
endmodule
`default_nettype wire

// [tb/rffe_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rffe_host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [31:0] rdata_in
);
  import rffe_pkg::*;
  // Bus idle at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; data inverted afterwards so stale values never pass
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // Read data is valid only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  // Self calibration: read first, then write back the level read
  task automatic self_cal(input logic [3:0] gear, output logic [31:0] first);
    rd_reg(RFFE_ADDR_CAL, first);
    wr_reg(RFFE_ADDR_CAL, {18'h0, gear, first[9:0]});
  endtask
  // Recommended filter word, which also picks timer 1
  task automatic emd_recommended();
    wr_reg(RFFE_ADDR_EMD, 32'h0000_0187);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rffe_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, got;
  logic wr_in, rd_in, cal_busy_out, noise_drop_out, err_notify_out;
  logic [3:0] dpc_gear_in = 4'h0;
  logic [9:0] meas_level_in = 10'h0;
  logic low_power_card_detect_start_in = 1'b0;
  logic card_mode_in = 1'b0;
  logic alm_in = 1'b0;
  logic tx_active_in = 1'b0;
  logic tx_envelope_in = 1'b1;
  logic rdr_mod_ctl_in = 1'b0;
  logic err_frame_in = 1'b0;
  logic [7:0] err_len_in = 8'h0;
  logic [3:0] cal_gear_out, card_carrier_conductance_out, card_modulation_conductance_out;
  logic [3:0] reader_modulation_conductance_out, reader_carrier_conductance_out;
  logic [9:0] cal_level_out;
  logic reader_max_output_select_out, carrier_reference_to_supply_out;
  logic [1:0] reader_carrier_amplitude_out;
  logic [2:0] supervision_timer_out;
  logic ant_short_out, ant_mod_out;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  rffe_cfg_regs dut_u (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .dpc_gear_in, .meas_level_in, .low_power_card_detect_start_in, .card_mode_in, .alm_in, .tx_active_in,
    .tx_envelope_in, .rdr_mod_ctl_in, .err_frame_in, .err_len_in, .cal_gear_out,
    .cal_level_out, .cal_busy_out, .card_carrier_conductance_out,
    .card_modulation_conductance_out, .reader_modulation_conductance_out,
    .reader_carrier_conductance_out, .reader_max_output_select_out,
    .reader_carrier_amplitude_out, .carrier_reference_to_supply_out,
    .supervision_timer_out, .noise_drop_out, .err_notify_out, .ant_short_out, .ant_mod_out);
  rffe_host_model host_u (.clk_in(clk_in), .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in), .rdata_in(rdata_out));
  // Word compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Let n edges pass, then sample settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Closing report
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, runs take a few hundred cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  // Reset values, unmapped address reads zero
  task automatic t_reset();
    chk("timer_rst", 32'h1, {29'h0, supervision_timer_out});
    for (int a = 8'h26; a <= 8'h2a; a++) begin
      host_u.rd_reg(8'(a), got);
      chk("reg_rst", 32'h0, got);
    end
    $display("test reset done");
  endtask
  // Drive fields, reserved bits dropped
  task automatic t_dpc();
    host_u.wr_reg(RFFE_ADDR_DPC, 32'hfffa_bcd5);
    host_u.rd_reg(RFFE_ADDR_DPC, got);
    chk("dpc_read", 32'h000a_bcd5, got);
    chk("dpc_fields", 32'h000a_bcd5, {12'h0, card_carrier_conductance_out,
      card_modulation_conductance_out, reader_modulation_conductance_out,
      reader_carrier_conductance_out, reader_max_output_select_out,
      reader_carrier_amplitude_out, carrier_reference_to_supply_out});
    $display("test dpc done");
  endtask
  // One errored frame; checks {noise, notify} then the pulse ends
  task automatic frame(input logic [7:0] len, input logic [1:0] exp);
    @(posedge clk_in);
    err_frame_in <= 1'b1;
    err_len_in <= len;
    @(posedge clk_in);
    err_frame_in <= 1'b0;
    err_len_in <= ~len;
    #1;
    chk("frame", {30'h0, exp}, {30'h0, noise_drop_out, err_notify_out});
    step(1);
    chk("frame_end", 32'h0, {30'h0, noise_drop_out, err_notify_out});
  endtask
  // Timer codes and noise filtering
  task automatic t_emd();
    for (int c = 0; c < 4; c++) begin
      host_u.wr_reg(RFFE_ADDR_EMD, 32'(c << 8));
      step(2);
      chk("timer", (c == 3) ? 32'h0 : 32'(1 << c), {29'h0, supervision_timer_out});
    end
    host_u.wr_reg(RFFE_ADDR_EMD, 32'hffff_ffff);
    host_u.rd_reg(RFFE_ADDR_EMD, got);
    chk("emd_read", 32'h3ff, got);
    host_u.emd_recommended();
    step(2);
    chk("timer", 32'h2, {29'h0, supervision_timer_out});
    frame(8'h00, 2'b10);
    frame(8'h03, 2'b10);
    frame(8'h04, 2'b01);
    host_u.wr_reg(RFFE_ADDR_EMD, 32'h0000_000d);
    frame(8'h02, 2'b10);
    frame(8'h03, 2'b01);
    host_u.wr_reg(RFFE_ADDR_EMD, 32'h0);
    frame(8'h00, 2'b01);
    $display("test emd done");
  endtask
  // Program antenna word, check {short, mod}
  task automatic ant_case(input logic [7:0] v, input logic [1:0] exp);
    host_u.wr_reg(RFFE_ADDR_ANT, {24'h0, v});
    step(2);
    chk("ant", {30'h0, exp}, {30'h0, ant_short_out, ant_mod_out});
  endtask
  // Passive codes, inversion, active modulation, reader source
  task automatic t_ant();
    logic e;
    @(posedge clk_in);
    card_mode_in <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_in);
        tx_envelope_in <= v[0];
        e = (c < 2) ? c[0] : (v[0] ^ c[0]);
        ant_case(8'(c * 5), {e, e});
      end
    end
    @(posedge clk_in);
    tx_active_in <= 1'b1;
    ant_case(8'h80, 2'b10);
    @(posedge clk_in);
    alm_in <= 1'b1;
    ant_case(8'h80, 2'b10);
    ant_case(8'hc0, 2'b01);
    ant_case(8'he0, 2'b00);
    @(posedge clk_in);
    card_mode_in <= 1'b0;
    alm_in <= 1'b0;
    rdr_mod_ctl_in <= 1'b1;
    tx_envelope_in <= 1'b0;
    ant_case(8'h10, 2'b01);
    ant_case(8'h00, 2'b00);
    // Reserved antenna bits are dropped on write and read back as zero
    host_u.wr_reg(RFFE_ADDR_ANT, 32'hffff_ff5a);
    host_u.rd_reg(RFFE_ADDR_ANT, got);
    chk("ant_read", 32'h0000_005a, got);
    $display("test ant done");
  endtask
  // Unwritten read calibrates, write sets gear and re-measures
  task automatic t_cal();
    @(posedge clk_in);
    dpc_gear_in <= 4'h9;
    meas_level_in <= 10'h2a5;
    step(4);
    host_u.self_cal(4'h3, got);
    meas_level_in <= 10'h15a;
    chk("cal_read", {18'h0, 4'h9, 10'h2a5}, got);
    step(1);
    chk("cal_gear", 32'h3, {28'h0, cal_gear_out});
    chk("cal_busy", 32'h1, {31'h0, cal_busy_out});
    for (int i = 0; i < 40 && cal_busy_out !== 1'b0; i++) begin
      step(1);
    end
    step(1);
    chk("cal_level", 32'h15a, {22'h0, cal_level_out});
    host_u.rd_reg(RFFE_ADDR_CAL, got);
    chk("cal_stored", {18'h0, 4'h3, 10'h15a}, got);
    // Detection start re-arms the read-triggered calibration on the new gear
    @(posedge clk_in);
    low_power_card_detect_start_in <= 1'b1;
    dpc_gear_in <= 4'h5;
    @(posedge clk_in);
    low_power_card_detect_start_in <= 1'b0;
    step(2);
    host_u.rd_reg(RFFE_ADDR_CAL, got);
    chk("cal_rearm", {18'h0, 4'h5, 10'h15a}, got);
    $display("test cal done");
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    step(2);
    t_reset();
    t_dpc();
    t_emd();
    t_ant();
    t_cal();
    finish_test();
  end
endmodule
`default_nettype wire
